/* File: peripheral_interrupt_flags_wake.v */
// Peripheral interrupt flags, enables, priorities and wake-up control
`timescale 1ns/1ps
`default_nettype none
`include "irq_flags_regs.vh"

// Operation
// - Pin-change flag follows any per-pin flag
// - Enable bits gate requests; bit 4 reads zero
// - Priority bit selects high or low level
// - Crystal wake waits 1024 oscillator periods
// - Start-up wait after crystal-mode wake and every reset
// - Global enable set: vector to 0004h
// - Global enable clear: continue after sleep
module peripheral_interrupt_flags_wake #(
  parameter OST_CYCLES = `OST_OSC_PERIODS
) (
  input wire sys_clk,
  input wire rst_n,
  input wire [`ADDR_WIDTH-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire [6:0] event_pulse,
  input wire [7:0] pin_change_pulse,
  input wire [7:0] source_req,
  output wire high_irq_req,
  output wire low_irq_req,
  output wire core_asleep,
  output wire core_ost_busy,
  output wire core_nop_slot,
  output wire core_vector_take,
  output wire core_resume_inline,
  output wire [15:0] core_vector_addr
);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg [6:0] event_flags_reg;
  reg [7:0] per_pin_change_flags_reg;
  reg [7:0] enables_reg;
  reg [7:0] priority_reg;
  reg [7:0] source_enables_reg;
  reg [7:0] core_ctrl_reg;
  reg [7:0] reg_rdata_next;
  reg [7:0] pin_sync1_reg;
  reg [7:0] pin_sync2_reg;
  reg [7:0] pin_sync3_reg;

  wire pin_change_event_flag;
  wire [7:0] peripheral_event_flags_0;
  wire [7:0] active_req;
  wire [7:0] source_gated;
  wire irq_pending;
  wire asleep;
  wire ost_busy;
  wire [7:0] core_status;
  wire [7:0] pin_agree;

  // Named views of register bits
  wire checksum_unit_event_flag;
  wire memory_scan_event_flag;
  wire nonvolatile_memory_event_flag;
  wire clock_switch_event_flag;
  wire oscillator_fail_event_flag;
  wire voltage_detect_event_flag;
  wire software_event_flag;

  wire logic_cell_irq_enable;
  wire waveform_gen_irq_enable;
  wire numeric_oscillator_irq_enable;
  wire capture_compare_irq_enable;
  wire second_timer_irq_enable;
  wire first_timer_gate_irq_enable;
  wire first_timer_irq_enable;
  wire [7:0] enable_vec;
  wire pin_change_priority;
  wire checksum_unit_priority;
  wire memory_scan_priority;
  wire nonvolatile_memory_priority;
  wire clock_switch_priority;
  wire oscillator_fail_priority;
  wire voltage_detect_priority;
  wire software_event_priority;
  wire [7:0] priority_vec;
  wire [7:0] high_active;
  wire [7:0] low_active;
  wire global_irq_enable;
  wire crystal_mode;
  wire sleep_req;

  function wr_hit;
    input [`ADDR_WIDTH-1:0] ofs;
    begin
      wr_hit = reg_wr && (reg_addr == ofs);
    end
  endfunction

  // --------------------------------------------------------------------------
  // Pin-change input synchroniser
  // --------------------------------------------------------------------------
  // Pulses come from pins; a change counts once stages two and three agree
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_sync1_reg <= 8'h00;
      pin_sync2_reg <= 8'h00;
      pin_sync3_reg <= 8'h00;
    end else begin
      pin_sync1_reg <= pin_change_pulse;
      pin_sync2_reg <= pin_sync1_reg;
      pin_sync3_reg <= pin_sync2_reg;
    end
  end

  assign pin_agree = pin_sync2_reg & pin_sync3_reg;

  // --------------------------------------------------------------------------
  // Event flags
  // --------------------------------------------------------------------------
  assign pin_change_event_flag = |per_pin_change_flags_reg;
  assign checksum_unit_event_flag = event_flags_reg[6];
  assign memory_scan_event_flag = event_flags_reg[5];
  assign nonvolatile_memory_event_flag = event_flags_reg[4];
  assign clock_switch_event_flag = event_flags_reg[3];
  assign oscillator_fail_event_flag = event_flags_reg[2];
  assign voltage_detect_event_flag = event_flags_reg[1];
  assign software_event_flag = event_flags_reg[0];
  // Summary bit on top; it has no storage of its own
  assign peripheral_event_flags_0 = {pin_change_event_flag,
    checksum_unit_event_flag, memory_scan_event_flag,
    nonvolatile_memory_event_flag, clock_switch_event_flag,
    oscillator_fail_event_flag, voltage_detect_event_flag,
    software_event_flag};

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      event_flags_reg <= 7'h00;
    end else begin
      // Set wins over a simultaneous software clear; enables not consulted
      if (wr_hit(`OFS_EVENT_FLAGS)) begin
        event_flags_reg <= reg_wdata[6:0] | event_pulse;
      end else begin
        event_flags_reg <= event_flags_reg | event_pulse;
      end
    end
  end

  // Writing 0 clears a pin flag; the summary flag is never written
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      per_pin_change_flags_reg <= `RST_PIN_FLAGS;
    end else begin
      if (wr_hit(`OFS_PIN_FLAGS)) begin
        per_pin_change_flags_reg <= (per_pin_change_flags_reg & reg_wdata)
          | pin_agree;
      end else begin
        per_pin_change_flags_reg <= per_pin_change_flags_reg | pin_agree;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Enables and priorities
  // --------------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      enables_reg <= `RST_EVENT_ENABLES;
      priority_reg <= `RST_EVENT_PRIORITY;
      source_enables_reg <= `RST_EVENT_ENABLES;
    end else begin
      if (wr_hit(`OFS_EVENT_ENABLES)) begin
        enables_reg <= reg_wdata & `ENABLES_IMPL_MASK;
      end
      if (wr_hit(`OFS_EVENT_PRIORITY)) begin
        priority_reg <= reg_wdata;
      end
      if (wr_hit(`OFS_SOURCE_ENABLES)) begin
        source_enables_reg <= reg_wdata;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Core control
  // --------------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      core_ctrl_reg <= `RST_CORE_CTRL;
    end else begin
      if (wr_hit(`OFS_CORE_CTRL)) begin
        core_ctrl_reg <= reg_wdata & 8'h07;
      end else if (asleep) begin
        // Sleep request is consumed once the sequencer is asleep
        core_ctrl_reg[`BIT_SLEEP_REQ] <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Named enable and priority bits
  // --------------------------------------------------------------------------
  assign logic_cell_irq_enable = enables_reg[7];
  assign waveform_gen_irq_enable = enables_reg[6];
  assign numeric_oscillator_irq_enable = enables_reg[5];
  assign capture_compare_irq_enable = enables_reg[3];
  assign second_timer_irq_enable = enables_reg[2];
  assign first_timer_gate_irq_enable = enables_reg[1];
  assign first_timer_irq_enable = enables_reg[0];
  // Bit 4 forced low here too, so a stray request there never passes
  assign enable_vec = {logic_cell_irq_enable, waveform_gen_irq_enable,
    numeric_oscillator_irq_enable, 1'b0, capture_compare_irq_enable,
    second_timer_irq_enable, first_timer_gate_irq_enable,
    first_timer_irq_enable};

  // One priority bit per flag; set means the high level
  assign pin_change_priority = priority_reg[7];
  assign checksum_unit_priority = priority_reg[6];
  assign memory_scan_priority = priority_reg[5];
  assign nonvolatile_memory_priority = priority_reg[4];
  assign clock_switch_priority = priority_reg[3];
  assign oscillator_fail_priority = priority_reg[2];
  assign voltage_detect_priority = priority_reg[1];
  assign software_event_priority = priority_reg[0];
  assign priority_vec = {pin_change_priority, checksum_unit_priority,
    memory_scan_priority, nonvolatile_memory_priority,
    clock_switch_priority, oscillator_fail_priority,
    voltage_detect_priority, software_event_priority};

  // Control bits handed to the wake sequencer
  assign global_irq_enable = core_ctrl_reg[`BIT_GLOBAL_EN];
  assign crystal_mode = core_ctrl_reg[`BIT_CRYSTAL_MODE];
  assign sleep_req = core_ctrl_reg[`BIT_SLEEP_REQ];

  // --------------------------------------------------------------------------
  // Request gating and priority routing
  // --------------------------------------------------------------------------
  assign active_req = peripheral_event_flags_0 & source_enables_reg;
  assign source_gated = source_req & enable_vec;
  assign irq_pending = (|active_req) | (|source_gated);
  assign high_active = active_req & priority_vec;
  assign low_active = active_req & ~priority_vec;
  assign high_irq_req = |high_active;
  // Enable-register sources have no priority bits; they ride low
  assign low_irq_req = (|low_active) | (|source_gated);

  // --------------------------------------------------------------------------
  // Wake sequencer
  // --------------------------------------------------------------------------
  wake_sequencer #(
    .OST_CYCLES(OST_CYCLES)
  ) u_wake (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sleep_req(sleep_req),
    .crystal_mode(crystal_mode),
    .global_irq_enable(global_irq_enable),
    .irq_pending(irq_pending),
    .asleep_reg(asleep),
    .ost_busy_reg(ost_busy),
    .nop_slot_reg(core_nop_slot),
    .vector_take_reg(core_vector_take),
    .resume_inline_reg(core_resume_inline),
    .vector_addr_reg(core_vector_addr)
  );

  assign core_asleep = asleep;
  assign core_ost_busy = ost_busy;
  assign core_status = {6'h00, ost_busy, asleep};

  // --------------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------------
  always @* begin
    case (reg_addr)
      `OFS_EVENT_FLAGS: reg_rdata_next = peripheral_event_flags_0;
      `OFS_EVENT_ENABLES: reg_rdata_next = enables_reg;
      `OFS_EVENT_PRIORITY: reg_rdata_next = priority_reg;
      `OFS_PIN_FLAGS: reg_rdata_next = per_pin_change_flags_reg;
      `OFS_CORE_CTRL: reg_rdata_next = core_ctrl_reg;
      `OFS_CORE_STATUS: reg_rdata_next = core_status;
      `OFS_SOURCE_ENABLES: reg_rdata_next = source_enables_reg;
      default: reg_rdata_next = 8'h00;
    endcase
  end

  // Data valid only in the cycle after the strobe; zero otherwise
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= reg_rdata_next;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // peripheral_interrupt_flags_wake

`default_nettype wire

/* File: irq_flags_regs.vh */
// Register offsets, reset values and timing counts for the interrupt block
`ifndef IRQ_FLAGS_REGS_VH
`define IRQ_FLAGS_REGS_VH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define ADDR_WIDTH 4
`define OFS_EVENT_FLAGS 4'h0
`define OFS_EVENT_ENABLES 4'h1
`define OFS_EVENT_PRIORITY 4'h2
`define OFS_PIN_FLAGS 4'h3
`define OFS_CORE_CTRL 4'h4
`define OFS_CORE_STATUS 4'h5
`define OFS_SOURCE_ENABLES 4'h6

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define BIT_PIN_CHANGE 7
`define ENABLES_IMPL_MASK 8'hef
`define RST_EVENT_FLAGS 8'h00
`define RST_EVENT_ENABLES 8'h00
`define RST_EVENT_PRIORITY 8'hff
`define RST_PIN_FLAGS 8'h00
`define RST_CORE_CTRL 8'h00
`define BIT_GLOBAL_EN 0
`define BIT_CRYSTAL_MODE 1
`define BIT_SLEEP_REQ 2

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define OST_OSC_PERIODS 1024
`define OST_CNT_WIDTH 11
`define FORCED_NOP_CYCLES 2
`define VECTOR_ADDR 16'h0004

`endif

/* File: wake_sequencer.v */
// Sleep, oscillator start-up wait and wake-up vectoring sequencer
`timescale 1ns/1ps
`default_nettype none
`include "irq_flags_regs.vh"

module wake_sequencer #(
  parameter OST_CYCLES = `OST_OSC_PERIODS
) (
  input wire sys_clk,
  input wire rst_n,
  input wire sleep_req,
  input wire crystal_mode,
  input wire global_irq_enable,
  input wire irq_pending,
  output reg asleep_reg,
  output reg ost_busy_reg,
  output reg nop_slot_reg,
  output reg vector_take_reg,
  output reg resume_inline_reg,
  output reg [15:0] vector_addr_reg
);

  localparam ST_RUN = 5'b00001;
  localparam ST_SLEEP = 5'b00010;
  localparam ST_OST = 5'b00100;
  localparam ST_NOP = 5'b01000;
  localparam ST_DECIDE = 5'b10000;
  localparam [31:0] NOP_LAST = `FORCED_NOP_CYCLES - 1;

  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg [`OST_CNT_WIDTH-1:0] cnt_reg;
  reg [`OST_CNT_WIDTH-1:0] cnt_next;
  reg ost_at_reset_reg;
  wire ost_done;

  assign ost_done = (cnt_reg == OST_CYCLES[`OST_CNT_WIDTH-1:0] - 11'h001);

  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg + 11'h001;
    case (state_reg)
      ST_RUN: begin
        cnt_next = 11'h000;
        if (sleep_req && !irq_pending) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        cnt_next = 11'h000;
        if (irq_pending) begin
          // Crystal modes wait; external clock and internal osc skip it
          state_next = crystal_mode ? ST_OST : ST_DECIDE;
        end
      end
      ST_OST: begin
        if (ost_done) begin
          cnt_next = 11'h000;
          state_next = ost_at_reset_reg ? ST_RUN : ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        cnt_next = 11'h000;
        state_next = global_irq_enable ? ST_NOP : ST_RUN;
      end
      ST_NOP: begin
        if (cnt_reg == NOP_LAST[`OST_CNT_WIDTH-1:0]) begin
          cnt_next = 11'h000;
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
        cnt_next = 11'h000;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      // Start-up wait after any reset; mode is not known yet, so apply it
      state_reg <= ST_OST;
      cnt_reg <= 11'h000;
      ost_at_reset_reg <= 1'b1;
      asleep_reg <= 1'b0;
      ost_busy_reg <= 1'b1;
      nop_slot_reg <= 1'b0;
      vector_take_reg <= 1'b0;
      resume_inline_reg <= 1'b0;
      vector_addr_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      if (state_reg == ST_OST && ost_done) begin
        ost_at_reset_reg <= 1'b0;
      end
      asleep_reg <= (state_next == ST_SLEEP);
      ost_busy_reg <= (state_next == ST_OST);
      nop_slot_reg <= (state_next == ST_NOP);
      vector_take_reg <= (state_reg == ST_NOP) && (state_next == ST_RUN);
      resume_inline_reg <= (state_reg == ST_DECIDE) && !global_irq_enable;
      if ((state_reg == ST_NOP) && (state_next == ST_RUN)) begin
        vector_addr_reg <= `VECTOR_ADDR;
      end
    end
  end

endmodule // wake_sequencer

`default_nettype wire

/* File: irq_flags_monitor.sv */
// Port-level checks on the interrupt flag and wake block
`timescale 1ns/1ps
`default_nettype none
`include "irq_flags_regs.vh"
module irq_flags_monitor #(
  parameter OST_CYCLES = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic high_irq_req,
  input wire logic low_irq_req,
  input wire logic core_ost_busy,
  input wire logic core_nop_slot,
  input wire logic core_vector_take,
  input wire logic core_resume_inline,
  input wire logic [15:0] core_vector_addr
);
  logic [15:0] ost_cnt_reg;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----
  // Start-up wait length, counted in cycles
  // ----
  always @(posedge sys_clk) begin
    if (!rst_n) ost_cnt_reg <= 16'h0000;
    else ost_cnt_reg <= core_ost_busy ? ost_cnt_reg + 16'h0001 : 16'h0000;
  end
  sequence s_nops;
    core_nop_slot [*2];
  endsequence
  AST_EN_BIT4: assert property (
    reg_rd && reg_addr == `OFS_EVENT_ENABLES |=> !reg_rdata[4])
    else $error("enable bit 4 read as one");
  AST_RST_REQ: assert property (
    $rose(rst_n) |-> !high_irq_req && !low_irq_req)
    else $error("request out of reset");
  AST_OST_LEN: assert property (
    $fell(core_ost_busy) |-> ost_cnt_reg >= OST_CYCLES - 1
      && ost_cnt_reg <= OST_CYCLES + 1)
    else $error("start-up wait length wrong");
  AST_RST_OST: assert property (
    $rose(rst_n) |-> core_ost_busy)
    else $error("no start-up wait after reset");
  AST_NOP_VEC: assert property (
    $rose(core_nop_slot) |-> s_nops ##1 core_vector_take)
    else $error("no-op slots not followed by vector");
  AST_TAKE_NOP: assert property (
    core_vector_take |-> $past(core_nop_slot) && $past(core_nop_slot, 2))
    else $error("vector without two no-ops");
  AST_VEC_ADDR: assert property (
    core_vector_take |-> core_vector_addr == `VECTOR_ADDR)
    else $error("wrong vector address");
  AST_EXCL: assert property (
    !(core_vector_take && core_resume_inline))
    else $error("vector and in-line at once");
endmodule // irq_flags_monitor
bind peripheral_interrupt_flags_wake irq_flags_monitor #(
  .OST_CYCLES(OST_CYCLES)
) mon_inst (.sys_clk, .rst_n, .reg_addr, .reg_rd, .reg_rdata,
  .high_irq_req, .low_irq_req, .core_ost_busy, .core_nop_slot,
  .core_vector_take, .core_resume_inline, .core_vector_addr);
`default_nettype wire

/* File: core_model.sv */
// Behavioural processor core that follows the wake-up outputs
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic core_nop_slot,
  input wire logic core_vector_take,
  input wire logic core_resume_inline,
  input wire logic [15:0] core_vector_addr,
  output logic [15:0] pc_reg,
  output logic [3:0] nop_cnt_reg
);
  // Nop count is cumulative so the bench can check totals
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      pc_reg <= 16'h0100;
      nop_cnt_reg <= 4'h0;
    end else begin
      if (core_nop_slot) nop_cnt_reg <= nop_cnt_reg + 4'h1;
      if (core_vector_take) pc_reg <= core_vector_addr;
      else if (core_resume_inline) pc_reg <= pc_reg + 16'h0001;
    end
  end
endmodule // core_model
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the interrupt flag and wake block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int OST = 8;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [6:0] event_pulse = 7'h00;
  logic [7:0] pin_change_pulse = 8'h00;
  logic [7:0] source_req = 8'h00;
  logic [7:0] reg_rdata, rv;
  logic high_irq_req, low_irq_req, core_asleep, core_ost_busy;
  logic core_nop_slot, core_vector_take, core_resume_inline;
  logic [15:0] core_vector_addr, pc_reg;
  logic [3:0] nop_cnt_reg;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int busy_n;
  always #2 sys_clk = ~sys_clk;
  peripheral_interrupt_flags_wake #(.OST_CYCLES(OST))
    peripheral_interrupt_flags_wake_inst (.sys_clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .event_pulse,
    .pin_change_pulse, .source_req, .high_irq_req, .low_irq_req,
    .core_asleep, .core_ost_busy, .core_nop_slot, .core_vector_take,
    .core_resume_inline, .core_vector_addr);
  core_model core_model_inst (.sys_clk, .rst_n, .core_nop_slot,
    .core_vector_take, .core_resume_inline, .core_vector_addr, .pc_reg,
    .nop_cnt_reg);
  // ----
  // Shared tasks
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic pulse(input logic [6:0] e, input logic [7:0] p);
    @(posedge sys_clk);
    event_pulse <= e;
    pin_change_pulse <= p;
    repeat (2) @(posedge sys_clk);
    event_pulse <= 7'h00;
    pin_change_pulse <= 8'h00;
    #1;
  endtask
  // Sleep, then wake on flag 0; counts start-up wait cycles
  task automatic doze(input logic [7:0] ctrl);
    int i;
    wr(4'h6, 8'h01);
    wr(4'h4, ctrl);
    i = 0;
    while (core_asleep !== 1'b1 && i < 20) begin
      @(posedge sys_clk);
      #1;
      i++;
    end
    chk(core_asleep, 1'b1);
    rd(4'h5);
    chk(rv, 8'h01);
    @(posedge sys_clk);
    event_pulse <= 7'h01;
    busy_n = 0;
    i = 0;
    while (!(core_vector_take === 1'b1 || core_resume_inline === 1'b1)
        && i < 60) begin
      @(posedge sys_clk);
      event_pulse <= 7'h00;
      #1;
      busy_n += (core_ost_busy === 1'b1);
      i++;
    end
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    rd(4'h1);
    chk(rv, 8'h00);
    rd(4'h2);
    chk(rv, 8'hff);
    rd(4'hf);
    chk(rv, 8'h00);
  endtask
  task automatic t_flags;
    pulse(7'h08, 8'h00);
    rd(4'h0);
    chk(rv, 8'h08);
    wr(4'h0, 8'hff);
    rd(4'h0);
    chk(rv, 8'h7f);
    wr(4'h0, 8'h00);
    rd(4'h0);
    chk(rv, 8'h00);
  endtask
  task automatic t_pins;
    pulse(7'h00, 8'h14);
    repeat (6) @(posedge sys_clk);
    rd(4'h3);
    chk(rv, 8'h14);
    wr(4'h0, 8'h00);
    rd(4'h0);
    chk(rv, 8'h80);
    wr(4'h3, 8'hef);
    rd(4'h0);
    chk(rv, 8'h80);
    wr(4'h3, 8'h00);
    rd(4'h0);
    chk(rv, 8'h00);
  endtask
  task automatic t_gate;
    wr(4'h1, 8'hff);
    rd(4'h1);
    chk(rv, 8'hef);
    @(posedge sys_clk);
    source_req <= 8'h10;
    @(posedge sys_clk);
    #1 chk(low_irq_req, 1'b0);
    @(posedge sys_clk);
    source_req <= 8'h01;
    @(posedge sys_clk);
    #1 chk(low_irq_req, 1'b1);
    chk(high_irq_req, 1'b0);
    @(posedge sys_clk);
    source_req <= 8'h00;
    wr(4'h1, 8'h00);
    wr(4'h6, 8'h01);
    pulse(7'h01, 8'h00);
    chk({high_irq_req, low_irq_req}, 2'b10);
    wr(4'h2, 8'hfe);
    chk({high_irq_req, low_irq_req}, 2'b01);
    wr(4'h6, 8'h00);
    chk(low_irq_req, 1'b0);
    wr(4'h0, 8'h00);
    wr(4'h2, 8'hff);
  endtask
  task automatic t_wake_vec;
    doze(8'h07);
    chk(busy_n, OST);
    chk(core_vector_take, 1'b1);
    @(posedge sys_clk);
    #1 chk(pc_reg, 16'h0004);
    chk(nop_cnt_reg, 4'h2);
    wr(4'h0, 8'h00);
  endtask
  task automatic t_wake_inline;
    doze(8'h04);
    chk(busy_n, 0);
    chk(core_resume_inline, 1'b1);
    @(posedge sys_clk);
    #1 chk(pc_reg, 16'h0005);
    wr(4'h0, 8'h00);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    busy_n = 0;
    while (core_ost_busy !== 1'b0 && busy_n < 50) begin
      @(posedge sys_clk);
      #1 busy_n++;
    end
    chk(busy_n >= OST && busy_n <= OST + 1, 1'b1);
    t_reset;
    t_flags;
    t_pins;
    t_gate;
    t_wake_vec;
    t_wake_inline;
    tally_and_finish;
  end
endmodule // tb_top
`default_nettype wire
